// ===== src/sfc_pkg.sv
// Shared constants of the fast-channel frame transmitter.
// Assumes a single 250 MHz clock and a 32-bit AXI4-Lite register bus.
package sfc_pkg;

  // -----------------------------------------------------------------
  // Clock and line timing
  // -----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int TICK_TIME_NS = 3000;
  localparam int TICK_CYCLES = (TICK_TIME_NS * CLK_MHZ) / 1000;
  localparam logic [7:0] SYNC_TICKS = 8'h38;
  localparam logic [7:0] NIB_BASE_TICKS = 8'h0c;
  localparam logic [7:0] LOW_TICKS = 8'h05;
  localparam logic [7:0] PAUSE_TICKS = 8'h4d;

  // -----------------------------------------------------------------
  // Register byte offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SECSEL = 8'h04;
  localparam logic [7:0] OFS_CLAMP = 8'h08;
  localparam logic [7:0] OFS_TEMP = 8'h0c;
  localparam logic [7:0] OFS_AMPL = 8'h10;
  localparam logic [7:0] OFS_ANGLE = 8'h14;
  localparam logic [7:0] OFS_STATBITS = 8'h18;
  localparam logic [7:0] OFS_SAMPLE = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // -----------------------------------------------------------------
  // Control, clamp and status field positions
  // -----------------------------------------------------------------
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_ERRSTAT = 6;
  localparam int CTRL_PAUSE = 8;
  localparam int CTRL_CRCTYPE = 11;
  localparam int CTRL_FMT_LO = 14;
  localparam int CLAMP_HI_LO = 16;
  localparam int STATUS_CNT_LO = 16;

  // -----------------------------------------------------------------
  // Reset values
  // -----------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [11:0] CLAMP_LOW_RESET = 12'h000;
  localparam logic [11:0] CLAMP_HIGH_RESET = 12'hfff;

  // -----------------------------------------------------------------
  // CRC constants
  // -----------------------------------------------------------------
  localparam logic [3:0] CRC_SEED = 4'h5;
  localparam logic [3:0] CRC_POLY = 4'hd;

  // -----------------------------------------------------------------
  // Enumerations
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    SFC_FMT_SINGLE = 2'b00,
    SFC_FMT_SECURE = 2'b01,
    SFC_FMT_DUAL = 2'b10,
    SFC_FMT_TWO_A7 = 2'b11
  } sfc_fmt_t;

  typedef enum logic [1:0] {
    SFC_SEC_TEMP = 2'b00,
    SFC_SEC_AMPL = 2'b01,
    SFC_SEC_ANGLE = 2'b10,
    SFC_SEC_NONE = 2'b11
  } sfc_sec_t;

  typedef enum logic {
    SFC_TX_IDLE = 1'b0,
    SFC_TX_PULSE = 1'b1
  } sfc_tx_t;

endpackage

// ===== src/sfc_fifo.sv
// Small FIFO of position samples from bus to framer.
// Assumes one clock; both sides use valid and ready.
`timescale 1ns/1ps
`default_nettype none
module sfc_fifo
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic doPush;
  logic doPop;

  // Flags follow the fill level.
  assign inReady = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign outValid = (level != '0);
  assign outData = mem[rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  // Storage takes only accepted pushes.
  always_ff @(posedge ref_clk)
  begin
    if (doPush)
    begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers wrap at the depth.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      if (doPush)
      begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop)
      begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
    end
  end

  // Level counts pushes against pops.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      level <= '0;
    end
    else if (doPush && !doPop)
    begin
      level <= level + 1'b1;
    end
    else if (doPop && !doPush)
    begin
      level <= level - 1'b1;
    end
  end

endmodule
`default_nettype wire

// ===== src/sfc_framer.sv
// Fast-channel frame transmitter with an AXI4-Lite register file.
// Assumes one 250 MHz clock; the line output drives one pin.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Two-channel formats send six data nibbles after status.
// - Dual throttle channel two is the negated position.
// - Dual throttle position is clamped to the clamp limits.
// - A.7 channel two carries a selectable secondary value.
// - Status bits 0-1 from error setting, 2-3 from slow channel.
// - Position fills three nibbles first, top nibble first.
// - Negated position goes bottom nibble first in pulses six to eight.
// - Secondary value goes bottom nibble first, source set by two bits.
// - A CRC nibble follows the data, type bit picks algorithm.
// - A pause pulse ends the frame only when the pause bit enables it.
// - Single channel: three nibbles, CRC pulse six, pause seven.
// - Single channel offers only the position sensor layout.
// - Format field picks single, secure, dual throttle or A.7.
// - CRC type 0 uses the recommended CRC, 1 the legacy CRC.
// - Pause bit 0 sends frames back to back, 1 inserts a pause.
// - Error status bit 0 forces error bits to zero.
module sfc_framer
  import sfc_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int FIFO_DEPTH = 8
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Line output, idles high
  output logic sentOut
);

  // -----------------------------------------------------------------
  // Helper functions
  // -----------------------------------------------------------------

  // Multiplies the CRC state by x^4 modulo the generator.
  function automatic logic [3:0] crcStep(input logic [3:0] c, input logic [3:0] n);
    logic [3:0] r;
    r = c;
    for (int b = 0; b < 4; b++)
    begin
      r = r[3] ? ({r[2:0], 1'b0} ^ CRC_POLY) : {r[2:0], 1'b0};
    end
    return r ^ n;
  endfunction

  // Byte-lane merge of a write into a stored word.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int k = 0; k < 4; k++)
    begin
      if (s[k])
      begin
        r[8*k +: 8] = d[8*k +: 8];
      end
    end
    return r;
  endfunction

  // -----------------------------------------------------------------
  // Register file and bus slave
  // -----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [1:0] secSel;
  logic [11:0] clampLow;
  logic [11:0] clampHigh;
  logic [11:0] tempVal;
  logic [11:0] amplVal;
  logic [11:0] angleVal;
  logic [3:0] statBits;
  logic awHave;
  logic wHave;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wrGo;
  logic wrSample;
  logic wrMapped;
  logic fifoInReady;
  logic fifoOutValid;
  logic [11:0] fifoOutData;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifoLevel;
  logic startFrame;
  sfc_tx_t txState;
  logic [15:0] frameCnt;
  logic [31:0] next_rdata;
  logic next_rok;

  // A sample write stalls its response while the FIFO is full.
  assign wrSample = (awAddr == OFS_SAMPLE);
  assign wrGo = awHave && wHave && !s_axi_bvalid && (!wrSample || fifoInReady);
  assign wrMapped = (awAddr <= OFS_SAMPLE) && (awAddr[1:0] == 2'b00);

  // Address and data land in either order, held until the response.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave <= 1'b1;
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (!awHave)
      begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (!wHave)
      begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        awHave <= 1'b0;
        wHave <= 1'b0;
      end
    end
  end

  // Write response; unmapped or status offsets answer with SLVERR.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else if (wrGo)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrMapped ? 2'b00 : 2'b10;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= CTRL_RESET;
      secSel <= SFC_SEC_TEMP;
      clampLow <= CLAMP_LOW_RESET;
      clampHigh <= CLAMP_HIGH_RESET;
      tempVal <= 12'h000;
      amplVal <= 12'h000;
      angleVal <= 12'h000;
      statBits <= 4'h0;
    end
    else if (wrGo)
    begin
      unique case (awAddr)
        OFS_CTRL: ctrl <= merge(ctrl, wData, wStrb);
        OFS_SECSEL: secSel <= wStrb[0] ? wData[1:0] : secSel;
        OFS_CLAMP:
        begin
          clampLow <= 12'(merge({20'h00000, clampLow}, wData, wStrb));
          clampHigh <= 12'(merge({4'h0, clampHigh, 16'h0000}, wData, wStrb) >> CLAMP_HI_LO);
        end
        OFS_TEMP: tempVal <= 12'(merge({20'h00000, tempVal}, wData, wStrb));
        OFS_AMPL: amplVal <= 12'(merge({20'h00000, amplVal}, wData, wStrb));
        OFS_ANGLE: angleVal <= 12'(merge({20'h00000, angleVal}, wData, wStrb));
        OFS_STATBITS: statBits <= wStrb[0] ? wData[3:0] : statBits;
        default: ;
      endcase
    end
  end

  // Read decode; status shows the framer's state.
  always_comb
  begin
    next_rok = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (s_axi_araddr)
      OFS_CTRL: next_rdata = ctrl & 32'h0000_c941;
      OFS_SECSEL: next_rdata = {30'h0, secSel};
      OFS_CLAMP: next_rdata = {4'h0, clampHigh, 4'h0, clampLow};
      OFS_TEMP: next_rdata = {20'h0, tempVal};
      OFS_AMPL: next_rdata = {20'h0, amplVal};
      OFS_ANGLE: next_rdata = {20'h0, angleVal};
      OFS_STATBITS: next_rdata = {28'h0, statBits};
      OFS_SAMPLE: next_rdata = 32'h0000_0000;
      OFS_STATUS: next_rdata = {frameCnt, 8'h00, 4'(fifoLevel), 3'b000, txState};
      default: next_rok = 1'b0;
    endcase
  end

  // Read data stand until the master takes them.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rok ? 2'b00 : 2'b10;
    end
    else if (s_axi_rvalid)
    begin
      s_axi_rvalid <= !s_axi_rready;
    end
    else
    begin
      s_axi_arready <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Sample FIFO
  // -----------------------------------------------------------------
  sfc_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(wrGo && wrSample),
    .inReady(fifoInReady),
    .inData(wData[11:0]),
    .outValid(fifoOutValid),
    .outReady(startFrame),
    .outData(fifoOutData),
    .level(fifoLevel)
  );

  // -----------------------------------------------------------------
  // Frame assembly
  // -----------------------------------------------------------------
  logic [11:0] lastPos;
  logic [11:0] rawPos;
  logic [11:0] curPos;
  logic [11:0] secVal;
  logic [11:0] chan2;
  logic [1:0] fmt;
  logic twoChan;
  logic [27:0] next_nibs;
  logic [3:0] next_crc;
  logic [27:0] nibs;
  logic [3:0] crcNib;
  logic [2:0] nData;
  logic pauseOn;

  assign fmt = ctrl[CTRL_FMT_LO +: 2];
  assign rawPos = fifoOutValid ? fifoOutData : lastPos;
  assign twoChan = (fmt == SFC_FMT_DUAL) || (fmt == SFC_FMT_TWO_A7);

  always_comb
  begin
    curPos = rawPos;
    if (fmt == SFC_FMT_DUAL)
    begin
      if (rawPos < clampLow)
      begin
        curPos = clampLow;
      end
      else if (rawPos > clampHigh)
      begin
        curPos = clampHigh;
      end
    end
  end

  always_comb
  begin
    unique case (secSel)
      SFC_SEC_TEMP: secVal = tempVal;
      SFC_SEC_AMPL: secVal = amplVal;
      SFC_SEC_ANGLE: secVal = angleVal;
      SFC_SEC_NONE: secVal = 12'h000;
    endcase
  end

  assign chan2 = (fmt == SFC_FMT_DUAL) ? (12'hfff - curPos) : secVal;

  // Nibble vector: slot 0 status, slots 1..6 data.
  always_comb
  begin
    next_nibs = 28'h0000000;
    next_nibs[1:0] = ctrl[CTRL_ERRSTAT] ? statBits[1:0] : 2'b00;
    next_nibs[3:2] = statBits[3:2];
    next_nibs[7:4] = curPos[11:8];
    next_nibs[11:8] = curPos[7:4];
    next_nibs[15:12] = curPos[3:0];
    if (twoChan)
    begin
      next_nibs[19:16] = chan2[3:0];
      next_nibs[23:20] = chan2[7:4];
      next_nibs[27:24] = chan2[11:8];
    end
  end

  always_comb
  begin
    next_crc = CRC_SEED;
    for (int i = 1; i < 7; i++)
    begin
      if (twoChan || i < 4)
      begin
        next_crc = crcStep(next_crc, next_nibs[4*i +: 4]);
      end
    end
    if (!ctrl[CTRL_CRCTYPE])
    begin
      next_crc = crcStep(next_crc, 4'h0);
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      lastPos <= 12'h000;
      nibs <= 28'h0000000;
      crcNib <= 4'h0;
      nData <= 3'd3;
      pauseOn <= 1'b0;
    end
    else if (startFrame)
    begin
      lastPos <= rawPos;
      nibs <= next_nibs;
      crcNib <= next_crc;
      nData <= twoChan ? 3'd6 : 3'd3;
      pauseOn <= ctrl[CTRL_PAUSE];
    end
  end

  // -----------------------------------------------------------------
  // Tick divider and pulse engine
  // -----------------------------------------------------------------
  logic [15:0] divCnt;
  logic tickEn;
  logic [7:0] tickCnt;
  logic [3:0] pIdx;
  logic [7:0] pLen;
  logic lastTick;
  logic lastPulse;
  logic [7:0] next_tick;

  // One tick enable every TICK_CYC clocks.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      divCnt <= 16'h0000;
      tickEn <= 1'b0;
    end
    else
    begin
      tickEn <= (divCnt == 16'(TICK_CYC - 1));
      divCnt <= (divCnt == 16'(TICK_CYC - 1)) ? 16'h0000 : divCnt + 1'b1;
    end
  end

  always_comb
  begin
    if (pIdx == 4'd0)
    begin
      pLen = SYNC_TICKS;
    end
    else if (pIdx <= 4'(nData) + 4'd1)
    begin
      pLen = NIB_BASE_TICKS + 8'(nibs[4*(pIdx-4'd1) +: 4]);
    end
    else if (pIdx == 4'(nData) + 4'd2)
    begin
      pLen = NIB_BASE_TICKS + 8'(crcNib);
    end
    else
    begin
      pLen = PAUSE_TICKS;
    end
  end

  assign lastTick = (tickCnt == pLen - 8'd1);
  assign lastPulse = (pIdx == 4'(nData) + (pauseOn ? 4'd3 : 4'd2));
  assign startFrame = tickEn && ctrl[CTRL_ENABLE] &&
                      ((txState == SFC_TX_IDLE) || (lastTick && lastPulse));
  assign next_tick = (startFrame || lastTick) ? 8'h00 : tickCnt + 8'd1;

  // Pulse sequencing; a disable finishes the frame first.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      txState <= SFC_TX_IDLE;
      tickCnt <= 8'h00;
      pIdx <= 4'h0;
      frameCnt <= 16'h0000;
    end
    else if (tickEn)
    begin
      unique case (txState)
        SFC_TX_IDLE:
        begin
          if (startFrame)
          begin
            txState <= SFC_TX_PULSE;
            tickCnt <= 8'h00;
            pIdx <= 4'h0;
          end
        end
        SFC_TX_PULSE:
        begin
          tickCnt <= next_tick;
          if (lastTick)
          begin
            pIdx <= lastPulse ? 4'h0 : pIdx + 4'd1;
            if (lastPulse)
            begin
              frameCnt <= frameCnt + 16'h0001;
              txState <= startFrame ? SFC_TX_PULSE : SFC_TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Line is low for the first ticks of each pulse, else high.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sentOut <= 1'b1;
    end
    else if (tickEn)
    begin
      if (startFrame || (txState == SFC_TX_PULSE && !(lastTick && lastPulse)))
      begin
        sentOut <= (next_tick < LOW_TICKS) ? 1'b0 : 1'b1;
      end
      else
      begin
        sentOut <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== bench/sfc_rx_model.sv
// Receiver model: times the line from one falling edge to the next.
// Assumes the line idles high and every frame opens with a sync pulse.
`timescale 1ns/1ps
`default_nettype none
module sfc_rx_model
  import sfc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Line in, decoded pulse length out
  input wire logic sentOut,
  output logic [7:0] pulseTicks,
  output logic pulseValid
);
  logic prevLine;
  logic started;
  int cnt;
  int calib;
  // Times each period; a sync sets the tick, long gaps are dropped.
  // tick from sync
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prevLine <= 1'b1;
      started <= 1'b0;
      cnt <= 0;
      calib <= 0;
      pulseTicks <= 8'h00;
      pulseValid <= 1'b0;
    end
    else
    begin
      prevLine <= sentOut;
      cnt <= cnt + 1;
      pulseValid <= 1'b0;
      if (prevLine && !sentOut)
      begin
        cnt <= 1;
        started <= 1'b1;
        if (started && (calib == 0 || (cnt > 50 * calib && cnt < 62 * calib)))
        begin
          calib <= cnt / 56;
          pulseTicks <= SYNC_TICKS;
          pulseValid <= 1'b1;
        end
        else if (started && cnt < 100 * calib)
        begin
          pulseTicks <= 8'((cnt + calib / 2) / calib);
          pulseValid <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/sfc_framer_checker.sv
// Checker of bus handshakes and line low time of the framer.
// Assumes one clock domain; bound to the framer below.
`timescale 1ns/1ps
`default_nettype none
module sfc_framer_checker
  import sfc_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Line
  input wire logic sentOut
);
  int lowCnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence arTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence bothTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Clocks of the present low phase.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      lowCnt <= 0;
    else
      lowCnt <= sentOut ? 0 : lowCnt + 1;
  end
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address slot still open");
  rd_answer_a: assert property (arTaken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rd_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
  rd_unmapped_a: assert property (arTaken ##0 s_axi_araddr > OFS_STATUS |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  wr_status_a: assert property (bothTaken ##0 s_axi_awaddr == OFS_STATUS |=> ##1 s_axi_bvalid && s_axi_bresp == 2'b10)
    else $error("status write not refused");
  low_time_a: assert property ($rose(sentOut) |-> lowCnt == LOW_TICKS * TICK_CYC)
    else $error("pulse low time wrong");
endmodule
bind sfc_framer sfc_framer_checker #(.TICK_CYC(TICK_CYC)) u_chk (.ref_clk, .rst, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .sentOut);
`default_nettype wire

// ===== bench/tb_sent_fast_channel_framer.sv
// Bench: bus tasks, frame decoding and one task per scenario.
// Assumes the receiver model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_sent_fast_channel_framer
  import sfc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sentOut, pulseValid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] pulseTicks;
  int n_mismatch = 0;
  int compares = 0;
  sfc_framer #(.TICK_CYC(4)) dut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sentOut);
  sfc_rx_model rx (.ref_clk, .rst, .sentOut, .pulseTicks, .pulseValid);
  // Clock of 4 ns.
  always #2 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 4000; k++)
    begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 4000; k++)
    begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, ed);
    chk(s_axi_rresp, er);
  endtask
  task automatic nextPulse(output logic [7:0] t);
    for (int k = 0; k < 2000; k++)
    begin
      @(posedge ref_clk);
      #1;
      if (pulseValid === 1'b1) break;
    end
    t = pulseTicks;
  endtask
  function automatic logic [3:0] crcStep(input logic [3:0] c, input logic [3:0] d);
    for (int i = 0; i < 4; i++) c = c[3] ? ({c[2:0], 1'b0} ^ CRC_POLY) : {c[2:0], 1'b0};
    return c ^ d;
  endfunction
  // Skips nSync syncs, checks one frame and the pulse after it.
  task automatic frameCheck(input int nd, input int nSync, input logic [3:0] st,
                            input logic [11:0] pos, input logic [11:0] sec, input logic ct,
                            input logic [7:0] tail);
    logic [7:0] t;
    logic [3:0] n [0:6] = '{st, pos[11:8], pos[7:4], pos[3:0], sec[3:0], sec[7:4], sec[11:8]};
    logic [3:0] c;
    int k;
    c = CRC_SEED;
    for (k = 1; k <= nd; k++) c = crcStep(c, n[k]);
    if (!ct) c = crcStep(c, 4'h0);
    while (nSync > 0)
    begin
      nextPulse(t);
      if (t === SYNC_TICKS) nSync--;
    end
    for (k = 0; k <= nd; k++)
    begin
      nextPulse(t);
      chk(t, NIB_BASE_TICKS + n[k]);
    end
    nextPulse(t);
    chk(t, NIB_BASE_TICKS + c);
    nextPulse(t);
    chk(t, tail);
  endtask
  // Reset values, an unmapped read and a refused write.
  task automatic t_regs();
    rd(OFS_CTRL, 32'hffffffff, CTRL_RESET, 2'b00);
    rd(OFS_CLAMP, 32'hffffffff, {4'h0, CLAMP_HIGH_RESET, 4'h0, CLAMP_LOW_RESET}, 2'b00);
    rd(8'h24, 32'hffffffff, 32'h0, 2'b10);
    wr(OFS_STATUS, 32'h0, 2'b10);
  endtask
  // Single and secure codes, error bits zeroed, no pause.
  task automatic t_single();
    int f;
    wr(OFS_STATBITS, 32'hb, 2'b00);
    wr(OFS_SAMPLE, 32'ha5c, 2'b00);
    for (f = 0; f < 2; f++)
    begin
      wr(OFS_CTRL, 32'h1 | (f << CTRL_FMT_LO), 2'b00);
      frameCheck(3, 2, 4'h8, 12'ha5c, 12'h0, 1'b0, SYNC_TICKS);
    end
  endtask
  // Dual throttle, both clamps, legacy CRC, pause.
  task automatic t_dual();
    logic [11:0] p [0:1] = '{12'hf12, 12'h050};
    logic [11:0] q [0:1] = '{12'he00, 12'h100};
    int f;
    wr(OFS_CLAMP, 32'h0e00_0100, 2'b00);
    wr(OFS_STATBITS, 32'h6, 2'b00);
    wr(OFS_CTRL, 32'h0000_8941, 2'b00);
    for (f = 0; f < 2; f++)
    begin
      wr(OFS_SAMPLE, 32'(p[f]), 2'b00);
      frameCheck(6, 2, 4'h6, q[f], 12'hfff - q[f], 1'b1, PAUSE_TICKS);
    end
  endtask
  // A.7 layout with every secondary source.
  task automatic t_a7();
    logic [11:0] v [0:3] = '{12'h123, 12'h456, 12'h789, 12'h000};
    int s;
    wr(OFS_TEMP, 32'h123, 2'b00);
    wr(OFS_AMPL, 32'h456, 2'b00);
    wr(OFS_ANGLE, 32'h789, 2'b00);
    wr(OFS_SAMPLE, 32'h3c7, 2'b00);
    wr(OFS_CTRL, 32'h0000_c001, 2'b00);
    for (s = 0; s < 4; s++)
    begin
      wr(OFS_SECSEL, 32'(s), 2'b00);
      frameCheck(6, 2, 4'h4, 12'h3c7, v[s], 1'b0, SYNC_TICKS);
    end
  endtask
  // Fills the buffer while stopped, overfills it, drains in order.
  task automatic t_fifo();
    int i;
    wr(OFS_CTRL, 32'h0, 2'b00);
    for (i = 1; i <= 8; i++) wr(OFS_SAMPLE, 32'h111 * i, 2'b00);
    repeat (1600) @(posedge ref_clk);
    rd(OFS_STATUS, 32'h0000_00f1, 32'h0000_0080, 2'b00);
    wr(OFS_CTRL, 32'h1, 2'b00);
    wr(OFS_SAMPLE, 32'h999, 2'b00);
    frameCheck(3, 1, 4'h4, 12'h111, 12'h0, 1'b0, SYNC_TICKS);
    frameCheck(3, 0, 4'h4, 12'h222, 12'h0, 1'b0, SYNC_TICKS);
    rd(OFS_STATUS, 32'h0000_00f0, 32'h0000_0060, 2'b00);
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence after the reset.
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_single();
    t_dual();
    t_a7();
    t_fifo();
    tally_and_finish();
  end
  // Cuts a hung run short.
  initial
  begin
    #200us;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
